// >>> npsg_params.svh
`ifndef NPSG_PARAMS_SVH
`define NPSG_PARAMS_SVH

// Register select codes on the control bus
`define NPSG_SEL_FREQ_LO    2'h0
`define NPSG_SEL_FREQ_HI    2'h1
`define NPSG_SEL_PHASE      2'h2
`define NPSG_SEL_RESERVED   2'h3

// Field positions and widths
`define NPSG_PHASE_W        32
`define NPSG_WORD_W         16
`define NPSG_LUT_ADDR_W     20
`define NPSG_LUT_ADDR_LSB   12
`define NPSG_KEY_ZERO_W     14

// Reset values
`define NPSG_RST_WORD       16'h0000
`define NPSG_RST_PHASE      32'h0000_0000

// Rotator depth and scaling
`define NPSG_ROT_STAGES     18
`define NPSG_ROT_W          21
`define NPSG_ROT_X0         21'h0136E8
`define NPSG_FULL_POS       16'h7FFF
`define NPSG_FULL_NEG       16'h8001

// Output buffer depth
`define NPSG_FIFO_DEPTH     16

`endif

// >>> npsg_pkg.sv
package npsg_pkg;
  // Control bus word and phase word
  typedef logic [15:0] npsgWord_t;
  typedef logic [31:0] npsgPhase_t;
  typedef logic [1:0]  npsgSel_t;
  // Sample pair carried to the multiplier: {sine, cosine}
  typedef logic [31:0] npsgPair_t;
endpackage : npsg_pkg

// >>> npsg_core.sv
// Function
// - Phase accumulator adds the 32-bit step each clock the sample buffer has room, wrapping modulo two to 32.
// - Phase step is center frequency plus offset frequency.
// - Step is two's complement; its sign picks lower or upper sideband.
// - Time accumulator overflow drives the active-low timer carry, its only output.
// - Phase carry output is the inverted phase accumulator overflow.
// - Phase register is added to the top 16 accumulator bits giving the argument.
// - Chip select low plus rising write strobe stores the bus by address; 11 reserved.
// - High and low frequency inputs form one 32-bit load source for three registers.
// - Center load enable is registered; register reloads every cycle while it stays low.
// - Source select high: phase register loads phase input while registered enable low.
// - Source select low: keying bits fill the top two phase bits, rest zero.
// - Offset gate low removes the offset contribution but keeps the stored value.
// - Accumulator load low zeroes feedback so the register takes the step.
// - Half range select limits the lookup phase to 0..180 or allows 0..360 degrees.
// - Time increment register loads the input word each clock while its enable low.
// - Timer init low zeroes timer feedback, suppressing carry and resetting its phase.
// - Lookup uses top 20 argument bits and yields 16-bit sine and cosine.
// - Address zero is zero radians; each step adds two pi over two to 20.
// - Lookup outputs are two's complement from 8001 to 7FFF; 8000 never appears.
// - Complex vector error stays below -90.2 dB of full scale at all phases.
// - Timer init low bypasses lookup: top phase bits on sine, low bits on cosine.
`include "npsg_params.svh"
`timescale 1ns/1ps
`default_nettype none

// Sample buffer between the generator and the multiplier
module npsg_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,       // System clock
  input  wire logic             rstN,      // Synchronised reset, active low
  input  wire logic             inValid,   // Write request
  output logic                  inReady,   // Room for one more word
  input  wire logic [WIDTH-1:0] inData,    // Write word
  output logic                  outValid,  // Word available
  input  wire logic             outReady,  // Reader takes the word
  output logic      [WIDTH-1:0] outData    // Head word
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [0:DEPTH-1];
  logic [AW-1:0]    wrPtr_q;
  logic [AW-1:0]    rdPtr_q;
  logic [AW:0]      count_q;
  logic             push;
  logic             pop;

  assign inReady  = (count_q != DEPTH[AW:0]);
  assign outValid = (count_q != '0);
  assign outData  = mem[rdPtr_q];
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;

  // Storage has no reset; only pointers and fill level are reset
  always_ff @(posedge clk)
  begin
    if (push)
      mem[wrPtr_q] <= inData;
  end

  // Pointers and fill level
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end
    else
    begin
      if (push)
        wrPtr_q <= wrPtr_q + 1'b1;
      if (pop)
        rdPtr_q <= rdPtr_q + 1'b1;
      if (push && !pop)
        count_q <= count_q + 1'b1;
      else if (pop && !push)
        count_q <= count_q - 1'b1;
    end
  end
endmodule // npsg_fifo

module npsg_generator (
  input  wire logic               clk,                // System clock, 125 MHz
  input  wire logic               rst_b,              // Asynchronous reset, active low
  input  wire npsg_pkg::npsgWord_t controlWordBus,    // Host data word
  input  wire npsg_pkg::npsgSel_t registerSelect,     // Host register address
  input  wire logic               chipSelectN,        // Host chip select
  input  wire logic               writeStrobeN,       // Host write strobe, stores on rise
  input  wire logic               centerFreqLoadN,    // Center frequency load enable
  input  wire logic               offsetFreqLoadN,    // Offset frequency load enable
  input  wire logic               phaseLoadN,         // Phase register load enable
  input  wire logic               phaseSourceSelect,  // 1: phase input, 0: keying bits
  input  wire logic [1:0]         quadKeyingInputs,   // Quadrature keying code
  input  wire logic               offsetGateN,        // Low removes offset from the step
  input  wire logic               halfRangeSelect,    // 1: modulo pi, 0: modulo two pi
  input  wire logic               timeIncrLoadN,      // Time increment load enable
  input  wire logic               timerInitBypassN,   // Timer init and lookup bypass
  input  wire logic               accumLoadN,         // Phase accumulator init
  input  wire logic               sampleReady,        // Multiplier takes a sample
  output logic                    sampleValid,        // Sample on sine and cosine
  output npsg_pkg::npsgWord_t     sineOut,            // Sine or bypassed top phase bits
  output npsg_pkg::npsgWord_t     cosineOut,          // Cosine or bypassed low phase bits
  output logic                    timerCarryN,        // Time accumulator carry, active low
  output logic                    phaseCarryOut       // Inverted phase accumulator carry
);
  import npsg_pkg::*;

  localparam int NS = `NPSG_ROT_STAGES;
  localparam int RW = `NPSG_ROT_W;
  localparam int PW = 31;
  // Arc tangent of two to minus i, in units of two pi over two to 20
  localparam logic signed [RW-1:0] ATAN [0:NS-1] = '{
    21'sd131072, 21'sd77376, 21'sd40884, 21'sd20753, 21'sd10417, 21'sd5213,
    21'sd2607, 21'sd1304, 21'sd652, 21'sd326, 21'sd163, 21'sd81,
    21'sd41, 21'sd20, 21'sd10, 21'sd5, 21'sd3, 21'sd1};

  logic [1:0]    rstSync_q;
  logic          rstN;
  logic [PW-1:0] pinRaw;
  logic [PW-1:0] pinS1_q;
  logic [PW-1:0] pinS2_q;
  npsgWord_t     busS;
  npsgSel_t      selS;
  logic          csNS, wrNS, cfNS, ofNS, phNS, pssS, ogNS, halfS, tiNS, tbNS, alNS;
  logic [1:0]    keyS;
  logic          wrNPrev_q;
  logic          wrRise;
  npsgWord_t     freqLo_q, freqHi_q, phaseIn_q, phaseReg_q;
  npsgPhase_t    freqWord;
  npsgPhase_t    centerFreq_q, offsetFreq_q, timeIncr_q, acc_q, tacc_q;
  logic          centerLoadN_q, offsetLoadN_q, phaseLoadN_q;
  npsgPhase_t    stepVal, argVal, lookupArg;
  logic [32:0]   accSum, timeSum;
  logic          advance;
  logic          fifoInReady;
  logic          fifoOutValid;
  npsgPair_t     fifoOutData;
  logic          fifoPop;
  npsgPair_t     pushData;

  // Reset release through two flip-flops
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      rstSync_q <= 2'b00;
    else
      rstSync_q <= {rstSync_q[0], 1'b1};
  end
  assign rstN = rstSync_q[1];

  // All pins except sampleReady pass two flip-flops before any logic reads them
  assign pinRaw = {controlWordBus, registerSelect, chipSelectN, writeStrobeN, centerFreqLoadN,
                   offsetFreqLoadN, phaseLoadN, phaseSourceSelect, quadKeyingInputs, offsetGateN,
                   halfRangeSelect, timeIncrLoadN, timerInitBypassN, accumLoadN};
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      pinS1_q <= {{18{1'b0}}, 13'h1FFF};
      pinS2_q <= {{18{1'b0}}, 13'h1FFF};
    end
    else
    begin
      pinS1_q <= pinRaw;
      pinS2_q <= pinS1_q;
    end
  end
  assign {busS, selS, csNS, wrNS, cfNS, ofNS, phNS, pssS, keyS, ogNS, halfS, tiNS, tbNS, alNS} = pinS2_q;

  // Strobe edge seen on the synchronised copy; bus was synchronised alongside it
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
      wrNPrev_q <= 1'b1;
    else
      wrNPrev_q <= wrNS;
  end
  assign wrRise = wrNS && !wrNPrev_q;

  // Host input registers; address 11 and chip select high store nothing
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      freqLo_q  <= `NPSG_RST_WORD;
      freqHi_q  <= `NPSG_RST_WORD;
      phaseIn_q <= `NPSG_RST_WORD;
    end
    else if (wrRise && !csNS)
    begin
      case (selS)
        `NPSG_SEL_FREQ_LO: freqLo_q  <= busS;
        `NPSG_SEL_FREQ_HI: freqHi_q  <= busS;
        `NPSG_SEL_PHASE:   phaseIn_q <= busS;
        default:           ;
      endcase
    end
  end
  assign freqWord = {freqHi_q, freqLo_q};

  // Registered copies of the center, offset and phase load enables; the time increment enable is used unregistered
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      centerLoadN_q <= 1'b1;
      offsetLoadN_q <= 1'b1;
      phaseLoadN_q  <= 1'b1;
    end
    else
    begin
      centerLoadN_q <= cfNS;
      offsetLoadN_q <= ofNS;
      phaseLoadN_q  <= phNS;
    end
  end

  // Frequency, phase and time increment registers
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      centerFreq_q <= `NPSG_RST_PHASE;
      offsetFreq_q <= `NPSG_RST_PHASE;
      timeIncr_q   <= `NPSG_RST_PHASE;
      phaseReg_q   <= `NPSG_RST_WORD;
    end
    else
    begin
      if (!centerLoadN_q)
        centerFreq_q <= freqWord;
      if (!offsetLoadN_q)
        offsetFreq_q <= freqWord;
      if (!tiNS)
        timeIncr_q <= freqWord;
      // Keying codes step 0, 90, 270, 180 degrees, so the second phase bit is the exclusive or
      if (!phaseLoadN_q)
        phaseReg_q <= pssS ? phaseIn_q : {keyS[1], keyS[1] ^ keyS[0], {`NPSG_KEY_ZERO_W{1'b0}}};
    end
  end

  // Step is a plain modular sum, so a negative step simply turns the other way
  assign stepVal   = centerFreq_q + (ogNS ? offsetFreq_q : '0);
  assign accSum    = {1'b0, (alNS ? acc_q : '0)} + {1'b0, stepVal};
  assign timeSum   = {1'b0, (tbNS ? tacc_q : '0)} + {1'b0, timeIncr_q};
  assign argVal    = acc_q + {phaseReg_q, 16'h0000};
  assign lookupArg = halfS ? {1'b0, argVal[30:0]} : argVal;

  // Phase accumulator holds while the sample buffer is full so no sample is lost
  assign advance = fifoInReady;
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      acc_q         <= `NPSG_RST_PHASE;
      phaseCarryOut <= 1'b1;
    end
    else if (advance)
    begin
      acc_q         <= accSum[31:0];
      phaseCarryOut <= ~accSum[32];
    end
  end

  // Time accumulator runs freely; it is a timer, not part of the sample path
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      tacc_q      <= `NPSG_RST_PHASE;
      timerCarryN <= 1'b1;
    end
    else
    begin
      tacc_q      <= timeSum[31:0];
      timerCarryN <= ~timeSum[32];
    end
  end

  // Rotator pipeline: quadrant from the top two address bits, residual angle rotated
  logic signed [RW-1:0] rx [0:NS];
  logic signed [RW-1:0] ry [0:NS];
  logic signed [RW-1:0] rz [0:NS];
  logic [1:0]           rq [0:NS];
  logic                 rv [0:NS];
  logic                 rb [0:NS];
  npsgPhase_t           ra [0:NS];

  // Stage 0 takes the lookup address: top 20 bits, zero at zero radians
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      rx[0] <= '0;
      ry[0] <= '0;
      rz[0] <= '0;
      rq[0] <= 2'b00;
      rv[0] <= 1'b0;
      rb[0] <= 1'b0;
      ra[0] <= '0;
    end
    else if (advance)
    begin
      rx[0] <= `NPSG_ROT_X0;
      ry[0] <= '0;
      rz[0] <= {3'b000, lookupArg[29:`NPSG_LUT_ADDR_LSB]};
      rq[0] <= lookupArg[31:30];
      rv[0] <= 1'b1;
      rb[0] <= !tbNS;
      ra[0] <= lookupArg;
    end
  end

  // Eighteen micro-rotations keep the vector error well under the required floor
  genvar gi;
  generate
    for (gi = 0; gi < NS; gi++)
    begin : g_rot
      always_ff @(posedge clk or negedge rstN)
      begin
        if (!rstN)
        begin
          rx[gi+1] <= '0;
          ry[gi+1] <= '0;
          rz[gi+1] <= '0;
          rq[gi+1] <= 2'b00;
          rv[gi+1] <= 1'b0;
          rb[gi+1] <= 1'b0;
          ra[gi+1] <= '0;
        end
        else if (advance)
        begin
          if (!rz[gi][RW-1])
          begin
            rx[gi+1] <= rx[gi] - (ry[gi] >>> gi);
            ry[gi+1] <= ry[gi] + (rx[gi] >>> gi);
            rz[gi+1] <= rz[gi] - ATAN[gi];
          end
          else
          begin
            rx[gi+1] <= rx[gi] + (ry[gi] >>> gi);
            ry[gi+1] <= ry[gi] - (rx[gi] >>> gi);
            rz[gi+1] <= rz[gi] + ATAN[gi];
          end
          rq[gi+1] <= rq[gi];
          rv[gi+1] <= rv[gi];
          rb[gi+1] <= rb[gi];
          ra[gi+1] <= ra[gi];
        end
      end
    end
  endgenerate

  // Round off two guard bits and clamp so negative full scale is 8001
  function automatic npsgWord_t npsgScale(input logic signed [RW-1:0] v);
    logic signed [RW-1:0] r;
    r = (v + 21'sd2) >>> 2;
    if (r > 21'sd32767)
      npsgScale = `NPSG_FULL_POS;
    else if (r < -21'sd32767)
      npsgScale = `NPSG_FULL_NEG;
    else
      npsgScale = r[15:0];
  endfunction

  // Quadrant fold back onto the full circle, or the bypass word
  npsgWord_t cosBase, sinBase, cosRot, sinRot;
  always_comb
  begin
    cosBase = npsgScale(rx[NS]);
    sinBase = npsgScale(ry[NS]);
    case (rq[NS])
      2'b00:   begin cosRot = cosBase;          sinRot = sinBase;          end
      2'b01:   begin cosRot = 16'h0000 - sinBase; sinRot = cosBase;        end
      2'b10:   begin cosRot = 16'h0000 - cosBase; sinRot = 16'h0000 - sinBase; end
      default: begin cosRot = sinBase;          sinRot = 16'h0000 - cosBase; end
    endcase
  end
  assign pushData = rb[NS] ? {ra[NS][31:16], ra[NS][15:0]} : {sinRot, cosRot};

  npsg_fifo #(
    .WIDTH (32),
    .DEPTH (`NPSG_FIFO_DEPTH)
  ) u_fifo (
    .clk      (clk),
    .rstN     (rstN),
    .inValid  (advance && rv[NS]),
    .inReady  (fifoInReady),
    .inData   (pushData),
    .outValid (fifoOutValid),
    .outReady (fifoPop),
    .outData  (fifoOutData)
  );

  // Output register refills whenever it is empty or being taken
  assign fifoPop = fifoOutValid && (!sampleValid || sampleReady);
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      sampleValid <= 1'b0;
      sineOut     <= `NPSG_RST_WORD;
      cosineOut   <= `NPSG_RST_WORD;
    end
    else if (!sampleValid || sampleReady)
    begin
      sampleValid <= fifoOutValid;
      if (fifoOutValid)
      begin
        sineOut   <= fifoOutData[31:16];
        cosineOut <= fifoOutData[15:0];
      end
    end
  end

  // Checks on the host registers, phase and timer paths and outputs
  acc_step_a : assert property (@(posedge clk) disable iff (!rstN)
    (advance && alNS) |=> (acc_q == $past(acc_q) + $past(stepVal)))
    else $error("phase accumulator did not add the step");
  acc_init_a : assert property (@(posedge clk) disable iff (!rstN)
    (advance && !alNS) |=> (acc_q == $past(stepVal)))
    else $error("accumulator load did not drop feedback");
  offset_gate_a : assert property (@(posedge clk) disable iff (!rstN)
    !ogNS |-> (stepVal == centerFreq_q))
    else $error("gated offset still reaches the step");
  phase_carry_a : assert property (@(posedge clk) disable iff (!rstN)
    (advance && alNS && $past(advance) && (acc_q[31] && stepVal[31])) |=> !phaseCarryOut)
    else $error("phase carry not shown inverted");
  timer_init_a : assert property (@(posedge clk) disable iff (!rstN)
    !tbNS |=> (tacc_q == $past(timeIncr_q)) && timerCarryN)
    else $error("timer init did not clear feedback");
  center_load_a : assert property (@(posedge clk) disable iff (!rstN)
    $fell(cfNS) |=> ##1 (centerFreq_q == $past(freqWord)))
    else $error("center frequency not loaded two edges after enable");
  keying_a : assert property (@(posedge clk) disable iff (!rstN)
    (!phaseLoadN_q && !pssS) |=> (phaseReg_q == {$past(keyS[1]), $past(keyS[1] ^ keyS[0]), 14'h0000}))
    else $error("keying bits not placed in phase register");
  write_lo_a : assert property (@(posedge clk) disable iff (!rstN)
    (wrRise && !csNS && selS == `NPSG_SEL_FREQ_LO) |=> (freqLo_q == $past(busS)))
    else $error("low frequency word not captured");
  half_range_a : assert property (@(posedge clk) disable iff (!rstN)
    (advance && halfS) |=> !rz[0][RW-1] && (ra[0][31] == 1'b0))
    else $error("modulo pi argument kept its top bit");
  out_range_a : assert property (@(posedge clk) disable iff (!rstN)
    (sampleValid && !rb[NS]) |-> (cosRot != 16'h8000) && (sinRot != 16'h8000))
    else $error("sine or cosine reached 8000");
  time_load_a : assert property (@(posedge clk) disable iff (!rstN)
    !tiNS |=> (timeIncr_q == $past(freqWord)))
    else $error("time increment not loaded");

  rollover_c : cover property (@(posedge clk) disable iff (!rstN) !phaseCarryOut);
  timer_tick_c : cover property (@(posedge clk) disable iff (!rstN) !timerCarryN);
  full_stall_c : cover property (@(posedge clk) disable iff (!rstN) !fifoInReady ##1 fifoInReady);
  bypass_c : cover property (@(posedge clk) disable iff (!rstN) sampleValid && rb[NS]);
endmodule // npsg_generator

`default_nettype wire

// >>> npsg_host.sv
`timescale 1ns/1ps
`default_nettype none

// Host side: writes control words over the bus and drives the load enables
module npsg_host (
  input  wire logic           clk,             // System clock
  output npsg_pkg::npsgWord_t controlWordBus,  // Data word to the device
  output npsg_pkg::npsgSel_t  registerSelect,  // Register address
  output logic                chipSelectN,     // Chip select, active low
  output logic                writeStrobeN,    // Write strobe, stores on rise
  output logic [3:0]          loadN            // Enables: center, offset, phase, time
);
  import npsg_pkg::*;

  // Idle state: deselected, strobe high, enables inactive
  initial
  begin
    controlWordBus = 16'h0000;
    registerSelect = 2'h0;
    chipSelectN    = 1'b1;
    writeStrobeN   = 1'b1;
    loadN          = 4'hF;
  end

  // One bus write; the word is held three clocks either side of the strobe rise
  // because the device sees the pins only after two synchroniser stages
  task automatic write(input npsgSel_t sel, input npsgWord_t data, input logic csN);
    @(negedge clk);
    controlWordBus = data;
    registerSelect = sel;
    chipSelectN    = csN;
    writeStrobeN   = 1'b0;
    repeat (3) @(negedge clk);
    writeStrobeN   = 1'b1;
    repeat (3) @(negedge clk);
    chipSelectN    = 1'b1;
    controlWordBus = ~data;     // Released bus shows no stale word
    registerSelect = ~sel;
    repeat (2) @(negedge clk);
  endtask

  // Both halves go in before any load enable is used
  task automatic writeFreq(input npsgPhase_t value);
    write(2'h0, value[15:0], 1'b0);
    write(2'h1, value[31:16], 1'b0);
  endtask

  // Hold one enable low long enough to pass the sync and registered stage
  task automatic load(input int idx);
    @(negedge clk);
    loadN[idx] = 1'b0;
    repeat (8) @(negedge clk);
    loadN[idx] = 1'b1;
    repeat (4) @(negedge clk);
  endtask
endmodule // npsg_host

`default_nettype wire

// >>> nco_phase_sine_generator_tb.sv
`timescale 1ns/1ps
`default_nettype none

module nco_phase_sine_generator_tb;
  import npsg_pkg::*;

  logic clk, rst_b, phaseSourceSelect, offsetGateN, halfRangeSelect;
  logic timerInitBypassN, accumLoadN, sampleReady, sampleValid, timerCarryN, phaseCarryOut;
  logic [1:0] quadKeyingInputs;
  logic [3:0] loadN;
  npsgWord_t controlWordBus, sineOut, cosineOut;
  npsgSel_t registerSelect;
  logic chipSelectN, writeStrobeN;
  int error_cnt = 0;
  int checked = 0;

  npsg_host i_npsg_host (.clk(clk), .controlWordBus(controlWordBus), .registerSelect(registerSelect),
    .chipSelectN(chipSelectN), .writeStrobeN(writeStrobeN), .loadN(loadN));

  npsg_generator i_npsg_generator (.clk(clk), .rst_b(rst_b), .controlWordBus(controlWordBus),
    .registerSelect(registerSelect), .chipSelectN(chipSelectN), .writeStrobeN(writeStrobeN),
    .centerFreqLoadN(loadN[0]), .offsetFreqLoadN(loadN[1]), .phaseLoadN(loadN[2]),
    .phaseSourceSelect(phaseSourceSelect), .quadKeyingInputs(quadKeyingInputs),
    .offsetGateN(offsetGateN), .halfRangeSelect(halfRangeSelect), .timeIncrLoadN(loadN[3]),
    .timerInitBypassN(timerInitBypassN), .accumLoadN(accumLoadN), .sampleReady(sampleReady),
    .sampleValid(sampleValid), .sineOut(sineOut), .cosineOut(cosineOut),
    .timerCarryN(timerCarryN), .phaseCarryOut(phaseCarryOut));

  // 125 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic conclude;
    $display("Comparisons %0d, mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("ERROR %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  // Let level changes clear the synchronisers and the sample pipeline
  task automatic settle;
    repeat (40) @(negedge clk);
  endtask

  // A sample seen valid at a falling edge is taken at the next rising edge
  task automatic getSample(output npsgPair_t s);
    int n;
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
    end
    while (sampleValid !== 1'b1 && n < 200);
    if (n >= 200)
      check(32'h0, 32'h1, "no sample");
    s = {sineOut, cosineOut};
  endtask

  task automatic countLow(input bit timer, input int n, output int c);
    c = 0;
    repeat (n)
    begin
      @(negedge clk);
      c += timer ? int'(timerCarryN === 1'b0) : int'(phaseCarryOut === 1'b0);
    end
  endtask

  // Bypass shows the argument itself; accumulator held at one step
  task automatic testBypass;
    npsgPair_t s, e;
    npsgPhase_t quarter [4] = '{32'h0000_0000, 32'h4000_0000, 32'hC000_0000, 32'h8000_0000};
    i_npsg_host.writeFreq(32'h0000_1234);
    i_npsg_host.load(0);
    for (int k = 0; k < 4; k++)
    begin
      quadKeyingInputs = 2'(k);
      halfRangeSelect = 1'b0;
      i_npsg_host.load(2);
      settle();
      getSample(s);
      e = 32'h0000_1234 + quarter[k];
      check(s, e, "keyed argument");
      halfRangeSelect = 1'b1;
      settle();
      getSample(s);
      check(s, e & 32'h7FFF_FFFF, "half range argument");
    end
    halfRangeSelect = 1'b0;
    phaseSourceSelect = 1'b1;
    i_npsg_host.write(2'h2, 16'h0ABC, 1'b0);
    i_npsg_host.load(2);
    settle();
    getSample(s);
    check(s, 32'h0ABC_1234, "phase offset argument");
    // Reserved address and deselected write must leave the phase untouched
    i_npsg_host.write(2'h3, 16'h5555, 1'b0);
    i_npsg_host.write(2'h2, 16'h7777, 1'b1);
    i_npsg_host.load(2);
    settle();
    getSample(s);
    check(s, 32'h0ABC_1234, "ignored writes");
    phaseSourceSelect = 1'b0;
    quadKeyingInputs = 2'h0;
    $display("testBypass done");
  endtask

  // Free accumulation: successive arguments differ by the step
  task automatic testAccum;
    npsgPair_t a, b;
    int c;
    bit ok;
    i_npsg_host.writeFreq(32'h0000_0100);
    i_npsg_host.load(1);
    i_npsg_host.writeFreq(32'h4000_0000);
    i_npsg_host.load(0);
    accumLoadN = 1'b1;
    offsetGateN = 1'b1;
    settle();
    getSample(a);
    getSample(b);
    check(b - a, 32'h4000_0100, "center plus offset");
    offsetGateN = 1'b0;
    settle();
    getSample(a);
    getSample(b);
    check(b - a, 32'h4000_0000, "gated offset");
    countLow(1'b0, 16, c);
    check(32'(c), 32'd4, "phase carries");
    i_npsg_host.writeFreq(32'hFFFF_FF00);
    i_npsg_host.load(0);
    settle();
    // Stall the reader; no sample may be lost across the stall
    sampleReady = 1'b0;
    repeat (40) @(negedge clk);
    sampleReady = 1'b1;
    getSample(a);
    ok = 1'b1;
    repeat (30)
    begin
      getSample(b);
      ok &= (b - a) === 32'hFFFF_FF00;
      a = b;
    end
    check(32'(ok), 32'h1, "negative step across stall");
    $display("testAccum done");
  endtask

  task automatic testTimer;
    int c;
    i_npsg_host.writeFreq(32'h4000_0000);
    i_npsg_host.load(3);
    timerInitBypassN = 1'b1;
    settle();
    countLow(1'b1, 32, c);
    check(32'(c), 32'd8, "timer carries");
    timerInitBypassN = 1'b0;
    settle();
    countLow(1'b1, 32, c);
    check(32'(c), 32'd0, "timer held");
    $display("testTimer done");
  endtask

  // Lookup at the four keyed quadrants, within a few LSB
  task automatic testLookup;
    npsgWord_t es [4] = '{16'h0000, 16'h7FFF, 16'h8001, 16'h0000};
    npsgWord_t ec [4] = '{16'h7FFF, 16'h0000, 16'h0000, 16'h8001};
    npsgPair_t s;
    int ds, dc;
    i_npsg_host.writeFreq(32'h0000_0000);
    i_npsg_host.load(0);
    accumLoadN = 1'b0;
    timerInitBypassN = 1'b1;
    for (int k = 0; k < 4; k++)
    begin
      quadKeyingInputs = 2'(k);
      i_npsg_host.load(2);
      settle();
      getSample(s);
      ds = int'($signed(s[31:16])) - int'($signed(es[k]));
      dc = int'($signed(s[15:0])) - int'($signed(ec[k]));
      check(32'(ds * ds <= 9 && dc * dc <= 9), 32'h1, "quadrant value");
      check(32'(s[31:16] !== 16'h8000 && s[15:0] !== 16'h8000), 32'h1, "range");
    end
    $display("testLookup done");
  endtask

  // Mid-run reset clears the outputs; nothing comes out before the pipeline refills
  task automatic testReset;
    @(negedge clk);
    rst_b = 1'b0;
    repeat (2) @(negedge clk);
    check({29'h0, sampleValid, timerCarryN, phaseCarryOut}, 32'h3, "outputs in reset");
    check({sineOut, cosineOut}, 32'h0, "sample in reset");
    rst_b = 1'b1;
    repeat (2) @(negedge clk);
    check({31'h0, sampleValid}, 32'h0, "early sample");
    settle();
    $display("testReset done");
  endtask

  // Watchdog
  initial
  begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    $display("ERROR %0t: timeout", $time);
    conclude();
  end

  initial
  begin
    rst_b = 1'b0;
    phaseSourceSelect = 1'b0;
    quadKeyingInputs = 2'h0;
    offsetGateN = 1'b0;
    halfRangeSelect = 1'b0;
    timerInitBypassN = 1'b0;
    accumLoadN = 1'b0;
    sampleReady = 1'b1;
    repeat (6) @(negedge clk);
    rst_b = 1'b1;
    repeat (5) @(negedge clk);
    testBypass();
    testAccum();
    testTimer();
    testLookup();
    testReset();
    conclude();
  end
endmodule // nco_phase_sine_generator_tb

`default_nettype wire
